/* File: rtl/pbsf_defs.vh */
`ifndef PBSF_DEFS_VH
`define PBSF_DEFS_VH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define PBSF_NCH          6
`define PBSF_AW           12
`define PBSF_DW           32

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PBSF_OFS_FLAGS    12'h0EC
`define PBSF_OFS_IRQ_STS  12'h100
`define PBSF_OFS_IRQ_CLR  12'h104
`define PBSF_OFS_IRQ_EN   12'h108

// ----------------------------------------------------------------------
// Field positions in the flag register and the interrupt registers
// ----------------------------------------------------------------------
`define PBSF_LSTS_LSB     24
`define PBSF_ESTS_LSB     16
`define PBSF_LIF_LSB      8
`define PBSF_EIF_LSB      0

// ----------------------------------------------------------------------
// Reset values, masks and responses
// ----------------------------------------------------------------------
`define PBSF_FLAGS_RST    32'h0000_0000
`define PBSF_IRQ_RST      32'h0000_0000
`define PBSF_IRQ_MASK     32'h0000_3F3F
`define PBSF_ZERO6        6'h00
`define PBSF_RESP_OKAY    2'h0
`define PBSF_RESP_SLVERR  2'h2

`endif

/* File: rtl/pbsf_chan.v */
`timescale 1ns/1ns
`include "pbsf_defs.vh"

// ----------------------------------------------------------------------
// One channel of brake tracking
// ----------------------------------------------------------------------
module pbsf_chan (
  input  wire aclk,
  input  wire aresetn,
  input  wire level_src_n,     // Enabled level brake sources, low = brake
  input  wire edge_src_n,      // Enabled edge brake sources, low = brake
  input  wire period_end,      // Pulse at end of the running period
  input  wire edge_state_clr,  // Software clear of edge state
  input  wire level_flag_clr,  // Software clear of level flag
  input  wire edge_flag_clr,   // Software clear of edge flag
  output wire level_state,     // Level brake state
  output wire edge_state,      // Edge brake state
  output wire level_flag,      // Level brake interrupt flag
  output wire edge_flag,       // Edge brake interrupt flag
  output wire level_event,     // One-cycle level brake event
  output wire edge_event,      // One-cycle edge brake event
  output wire out_en           // Channel waveform may be driven
);

  reg  level_prev_reg;         // Last level source sample
  reg  edge_prev_reg;          // Last edge source sample
  reg  level_state_reg;        // Level brake state
  reg  edge_state_reg;         // Edge brake state
  reg  level_flag_reg;         // Level interrupt flag
  reg  edge_flag_reg;          // Edge interrupt flag
  reg  out_en_reg;             // Waveform enable
  wire level_fall;             // Falling edge of level source
  wire edge_fall;              // Falling edge of edge source
  wire level_release;          // Level brake ends this cycle

  // Falling edges of the brake sources
  assign level_fall    = level_prev_reg & ~level_src_n;
  assign edge_fall     = edge_prev_reg & ~edge_src_n;
  // Release only once sources are high and the period has ended
  assign level_release = level_state_reg & level_src_n
                         & period_end;

  // ----------------------------------------------------------------------
  // State and flag registers
  // ----------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_prev_reg  <= 1'b1;
      edge_prev_reg   <= 1'b1;
      level_state_reg <= 1'b0;
      edge_state_reg  <= 1'b0;
      level_flag_reg  <= 1'b0;
      edge_flag_reg   <= 1'b0;
      out_en_reg      <= 1'b1;
    end
    else
    begin
      level_prev_reg <= level_src_n;
      edge_prev_reg  <= edge_src_n;
      // Level state: set by hardware, cleared only by release
      if (level_fall)
        level_state_reg <= 1'b1;
      else if (level_release)
        level_state_reg <= 1'b0;
      // Edge state: set wins over the software clear
      if (edge_fall)
        edge_state_reg <= 1'b1;
      else if (edge_state_clr)
        edge_state_reg <= 1'b0;
      // Interrupt flags, set wins
      if (level_fall)
        level_flag_reg <= 1'b1;
      else if (level_flag_clr)
        level_flag_reg <= 1'b0;
      if (edge_fall)
        edge_flag_reg <= 1'b1;
      else if (edge_flag_clr)
        edge_flag_reg <= 1'b0;
      // Output stops at once and resumes only on a period boundary
      if (level_fall | edge_fall)
        out_en_reg <= 1'b0;
      else if (!out_en_reg && period_end && !edge_state_reg
               && (!level_state_reg || level_release))
        out_en_reg <= 1'b1;
    end
  end

  assign level_state = level_state_reg;
  assign edge_state  = edge_state_reg;
  assign level_flag  = level_flag_reg;
  assign edge_flag   = edge_flag_reg;
  assign level_event = level_fall;
  assign edge_event  = edge_fall;
  assign out_en      = out_en_reg;

endmodule

/* File: rtl/pbsf_top.v */
`timescale 1ns/1ns
`include "pbsf_defs.vh"

// ----------------------------------------------------------------------
// Brake status and flag block with AXI4-Lite slave
// ----------------------------------------------------------------------
module pbsf_top (
  input  wire        aclk,
  input  wire        aresetn,
  // Write address channel
  input  wire [11:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // Write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // Write response channel
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // Read address channel
  input  wire [11:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // Read data channel
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Brake side
  input  wire [5:0]  level_brake_src_n,
  input  wire [5:0]  edge_brake_src_n,
  input  wire [5:0]  period_end,
  input  wire        register_write_lock,
  output wire [5:0]  chan_out_en,
  output wire        irq
);

  // ----------------------------------------------------------------------
  // Local state codes
  // ----------------------------------------------------------------------
  localparam [1:0] WS_IDLE = 2'h1;    // Collecting address and data
  localparam [1:0] WS_RESP = 2'h2;    // Response offered
  localparam [1:0] RS_IDLE = 2'h1;    // Waiting for read address
  localparam [1:0] RS_RESP = 2'h2;    // Read data offered

  // ----------------------------------------------------------------------
  // Bus slave registers
  // ----------------------------------------------------------------------
  reg  [1:0]  wstate_reg;             // Write state
  reg  [1:0]  rstate_reg;             // Read state
  reg         awready_reg;            // Address slot free
  reg         wready_reg;             // Data slot free
  reg         aw_got_reg;             // Address held
  reg         w_got_reg;              // Data held
  reg  [11:0] awaddr_reg;             // Held write address
  reg  [31:0] wdata_reg;              // Held write data
  reg  [3:0]  wstrb_reg;              // Held byte strobes
  reg         bvalid_reg;             // Write response valid
  reg  [1:0]  bresp_reg;              // Write response code
  reg         arready_reg;            // Read address slot free
  reg         rvalid_reg;             // Read data valid
  reg  [31:0] rdata_reg;              // Read data
  reg  [1:0]  rresp_reg;              // Read response code

  // ----------------------------------------------------------------------
  // Interrupt registers
  // ----------------------------------------------------------------------
  reg  [31:0] irq_sts_reg;            // Sticky event bits
  reg  [31:0] irq_en_reg;             // Interrupt enables
  reg         irq_reg;                // Interrupt output
  reg  [31:0] irq_sts_next;           // Next sticky value

  // ----------------------------------------------------------------------
  // Decode, register image and channel signals
  // ----------------------------------------------------------------------
  wire        wr_en;                  // Write performed this cycle
  wire [3:0]  wr_sel;                 // One-hot write target
  wire [3:0]  rd_sel;                 // One-hot read target
  wire [31:0] wr_ones;                // Written ones under strobes
  wire [31:0] flags_word;             // Flag register image
  wire [31:0] ev_word;                // Events in interrupt layout
  wire [5:0]  edge_state_clr;         // Edge state clear strobes
  wire [5:0]  level_flag_clr;         // Level flag clear strobes
  wire [5:0]  edge_flag_clr;          // Edge flag clear strobes
  wire [5:0]  level_state;            // Per-channel level states
  wire [5:0]  edge_state;             // Per-channel edge states
  wire [5:0]  level_flag;             // Per-channel level flags
  wire [5:0]  edge_flag;              // Per-channel edge flags
  wire [5:0]  level_event;            // Per-channel level events
  wire [5:0]  edge_event;             // Per-channel edge events

  // ----------------------------------------------------------------------
  // Address decode, shared by the read and write paths
  // ----------------------------------------------------------------------
  function [3:0] reg_sel;
    input [11:0] addr;
    begin
      case (addr)
        `PBSF_OFS_FLAGS:   reg_sel = 4'h1;
        `PBSF_OFS_IRQ_STS: reg_sel = 4'h2;
        `PBSF_OFS_IRQ_CLR: reg_sel = 4'h4;
        `PBSF_OFS_IRQ_EN:  reg_sel = 4'h8;
        default:           reg_sel = 4'h0;
      endcase
    end
  endfunction

  // Expand byte strobes into a bit mask
  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}},
                   {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  assign wr_en   = (wstate_reg == WS_IDLE) & aw_got_reg & w_got_reg;
  assign wr_sel  = wr_en ? reg_sel(awaddr_reg) : 4'h0;
  assign rd_sel  = reg_sel(s_axi_araddr);
  // In the clear writes only written ones act; zeros leave bits unchanged (the enable register takes zeros under strobes)
  assign wr_ones = wdata_reg & strb_mask(wstrb_reg);

  // ----------------------------------------------------------------------
  // Clear strobes toward the channels
  // ----------------------------------------------------------------------
  // Edge state is cleared by a written one
  assign edge_state_clr = wr_sel[0] ?
    wr_ones[`PBSF_ESTS_LSB+5:`PBSF_ESTS_LSB] : `PBSF_ZERO6;
  // Interrupt flags ignore clears while the lock is set
  assign level_flag_clr = (wr_sel[0] && !register_write_lock) ?
    wr_ones[`PBSF_LIF_LSB+5:`PBSF_LIF_LSB] : `PBSF_ZERO6;
  assign edge_flag_clr  = (wr_sel[0] && !register_write_lock) ?
    wr_ones[`PBSF_EIF_LSB+5:`PBSF_EIF_LSB] : `PBSF_ZERO6;

  // ----------------------------------------------------------------------
  // Six channel instances
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PBSF_NCH; gi = gi + 1)
    begin : g_chan
      pbsf_chan u_chan (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .level_src_n    (level_brake_src_n[gi]),
        .edge_src_n     (edge_brake_src_n[gi]),
        .period_end     (period_end[gi]),
        .edge_state_clr (edge_state_clr[gi]),
        .level_flag_clr (level_flag_clr[gi]),
        .edge_flag_clr  (edge_flag_clr[gi]),
        .level_state    (level_state[gi]),
        .edge_state     (edge_state[gi]),
        .level_flag     (level_flag[gi]),
        .edge_flag      (edge_flag[gi]),
        .level_event    (level_event[gi]),
        .edge_event     (edge_event[gi]),
        .out_en         (chan_out_en[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------------
  // Reserved positions are tied to zero
  assign flags_word = {2'h0, level_state,
                       2'h0, edge_state,
                       2'h0, level_flag,
                       2'h0, edge_flag};
  // Events in the same layout as the flag bits
  assign ev_word    = {18'h00000, level_event, 2'h0, edge_event};

  // ----------------------------------------------------------------------
  // Write channel handling
  // ----------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate_reg  <= WS_IDLE;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PBSF_RESP_OKAY;
    end
    else
    begin
      case (wstate_reg)
        WS_IDLE:
        begin
          // Address may come before, with or after the data
          if (s_axi_awvalid && awready_reg)
          begin
            awaddr_reg  <= s_axi_awaddr;
            aw_got_reg  <= 1'b1;
            awready_reg <= 1'b0;
          end
          // Data slot
          if (s_axi_wvalid && wready_reg)
          begin
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
            w_got_reg  <= 1'b1;
            wready_reg <= 1'b0;
          end
          // Both held: write happens now, response next
          if (wr_en)
          begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (reg_sel(awaddr_reg) == 4'h0) ?
                          `PBSF_RESP_SLVERR : `PBSF_RESP_OKAY;
            wstate_reg <= WS_RESP;
          end
        end
        WS_RESP:
        begin
          // Hold the response until the master takes it
          if (s_axi_bready)
          begin
            bvalid_reg  <= 1'b0;
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            wstate_reg  <= WS_IDLE;
          end
        end
        default:
        begin
          wstate_reg <= WS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read channel handling
  // ----------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rstate_reg  <= RS_IDLE;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `PBSF_RESP_OKAY;
    end
    else
    begin
      case (rstate_reg)
        RS_IDLE:
        begin
          // Capture data at the address handshake
          if (s_axi_arvalid && arready_reg)
          begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rstate_reg  <= RS_RESP;
            case (rd_sel)
              4'h1:    rdata_reg <= flags_word;
              4'h2:    rdata_reg <= irq_sts_reg;
              4'h8:    rdata_reg <= irq_en_reg;
              default: rdata_reg <= 32'h0000_0000;
            endcase
            rresp_reg <= (rd_sel == 4'h0) ?
                         `PBSF_RESP_SLVERR : `PBSF_RESP_OKAY;
          end
        end
        RS_RESP:
        begin
          // Hold data until the master takes it
          if (s_axi_rready)
          begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
            rstate_reg  <= RS_IDLE;
          end
        end
        default:
        begin
          rstate_reg <= RS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, enable and output
  // ----------------------------------------------------------------------
  // Clear first, then set, so a same-cycle event survives
  always @*
  begin
    irq_sts_next = irq_sts_reg;
    if (wr_sel[2])
      irq_sts_next = irq_sts_next & ~wr_ones;
    irq_sts_next = irq_sts_next | ev_word;
  end

  // Status, enable and the level output
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_sts_reg <= `PBSF_IRQ_RST;
      irq_en_reg  <= `PBSF_IRQ_RST;
      irq_reg     <= 1'b0;
    end
    else
    begin
      irq_sts_reg <= irq_sts_next;
      // Enable register, bytes under strobes, reserved held low
      if (wr_sel[3])
        irq_en_reg <= ((irq_en_reg & ~strb_mask(wstrb_reg))
                      | wr_ones) & `PBSF_IRQ_MASK;
      irq_reg <= |(irq_sts_next & irq_en_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Output wiring from flip-flops
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign irq           = irq_reg;

endmodule

/* File: verif/pbsf_checker_properties.sv */
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Port-level checks of the brake status block
// ----------------------------------------------------------------------
module pbsf_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire [5:0]  level_brake_src_n,
  input wire [5:0]  edge_brake_src_n,
  input wire [5:0]  period_end,
  input wire [5:0]  chan_out_en,
  input wire        irq
);
  // One domain, reset disables every check
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_level_trip:
    assert property ($fell(level_brake_src_n[0]) |=> !chan_out_en[0])
    else $error("channel 0 kept running after level trip");
  chk_edge_trip:
    assert property ($fell(edge_brake_src_n[5]) |=> !chan_out_en[5])
    else $error("channel 5 kept running after edge trip");
  chk_brake_hold:
    assert property (!chan_out_en[0] && !level_brake_src_n[0]
                     |=> !chan_out_en[0])
    else $error("channel 0 resumed while source low");
  chk_resume_period:
    assert property ($rose(chan_out_en[0]) |-> $past(period_end[0]))
    else $error("channel 0 resumed off a period end");
  chk_reset_state:
    assert property ($rose(aresetn) |-> chan_out_en == 6'h3F && !irq)
    else $error("outputs not at reset level");
  chk_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                     s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_write_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_unmapped_read:
    assert property (s_axi_arvalid && s_axi_arready &&
                     s_axi_araddr == 12'h0F0
                     |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind pbsf_top pbsf_checker pbsf_checker_i (.*);

/* File: verif/pbsf_brake_model.sv */
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Brake source pins and period events of the modulator
// ----------------------------------------------------------------------
module pbsf_brake_model (
  input  wire        aclk,
  output logic [5:0] level_brake_src_n,  // Low = brake
  output logic [5:0] edge_brake_src_n,   // Low = brake
  output logic [5:0] period_end          // One-cycle pulse
);
  // Sources idle high, no period running out
  initial
  begin
    level_brake_src_n = 6'h3F;
    edge_brake_src_n  = 6'h3F;
    period_end        = 6'h00;
  end

  // Set both source groups at the next edge
  task automatic drive(input logic [5:0] lvl, input logic [5:0] edg);
    @(posedge aclk);
    level_brake_src_n <= lvl;
    edge_brake_src_n  <= edg;
  endtask

  // End the running period after a delay, prompt or slow
  task automatic period(input logic [5:0] m, input int dly);
    repeat (dly) @(posedge aclk);
    @(posedge aclk);
    period_end <= m;
    @(posedge aclk);
    period_end <= 6'h00;
  endtask
endmodule

/* File: verif/pbsf_brake_status_flags_bench.sv */
`timescale 1ns/1ns
`include "pbsf_defs.vh"

module pbsf_brake_status_flags_bench;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] r;} pbsf_row_t;
  logic        aclk, aresetn, register_write_lock;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, irq;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [5:0]  level_brake_src_n, edge_brake_src_n, period_end, chan_out_en;
  int          fail_count, n_tests;
  pbsf_row_t   rows [4];

  pbsf_top pbsf_top_i (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));
  pbsf_brake_model pbsf_brake_model_i (.*);

  // Clock, 8 ns period
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Hang guard
  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Bus read into rv and rs
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] exp);
    rd(a);
    chk(nm, rv, exp);
  endtask

  task automatic fl(input logic [31:0] exp);
    rd_chk("flags", `PBSF_OFS_FLAGS, exp);
  endtask

  // Reset values from the row table
  task automatic reset_table;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("reset read", rv, rows[i].d);
      chk("reset resp", {30'h0, rs}, {30'h0, rows[i].r});
    end
    chk("out_en", {26'h0, chan_out_en}, 32'h3F);
    $display("reset table done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    register_write_lock = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    rows[0] = '{`PBSF_OFS_FLAGS, 32'h0, `PBSF_RESP_OKAY};
    rows[1] = '{`PBSF_OFS_IRQ_STS, 32'h0, `PBSF_RESP_OKAY};
    rows[2] = '{`PBSF_OFS_IRQ_EN, 32'h0, `PBSF_RESP_OKAY};
    rows[3] = '{12'h0F0, 32'h0, `PBSF_RESP_SLVERR};
    tick(6);
    aresetn <= 1'b1;
    reset_table();
    // Edge trip on every channel, interrupt raised then masked
    pbsf_brake_model_i.drive(6'h3F, 6'h00);
    tick(2);
    chk("out_en", {26'h0, chan_out_en}, 32'h0);
    pbsf_brake_model_i.drive(6'h3F, 6'h3F);
    fl(32'h003F_003F);
    rd_chk("irq sts", `PBSF_OFS_IRQ_STS, 32'h0000_003F);
    wr(`PBSF_OFS_IRQ_EN, 32'h0000_3F3F);
    tick(2);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(`PBSF_OFS_IRQ_EN, 32'h0);
    tick(2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`PBSF_OFS_IRQ_EN, 32'h0000_3F3F);
    // Zero writes, reserved and read-only bits, unmapped write
    wr(`PBSF_OFS_FLAGS, 32'h0);
    wr(`PBSF_OFS_FLAGS, 32'hFFC0_C0C0);
    fl(32'h003F_003F);
    wr(12'h0F0, 32'hFFFF_FFFF);
    chk("unmapped", {30'h0, rs}, {30'h0, `PBSF_RESP_SLVERR});
    // Protected clears refused while locked
    register_write_lock <= 1'b1;
    wr(`PBSF_OFS_FLAGS, 32'h0000_3F3F);
    fl(32'h003F_003F);
    wr(`PBSF_OFS_FLAGS, 32'h003F_0000);
    fl(32'h0000_003F);
    register_write_lock <= 1'b0;
    wr(`PBSF_OFS_FLAGS, 32'h0000_003F);
    fl(32'h0);
    wr(`PBSF_OFS_IRQ_CLR, 32'h0000_3F3F);
    tick(2);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    pbsf_brake_model_i.period(6'h3F, 3);
    tick(1);
    chk("out_en", {26'h0, chan_out_en}, 32'h3F);
    $display("edge test done");
    // Level trip on channels 0 and 5, release on period ends
    pbsf_brake_model_i.drive(6'h1E, 6'h3F);
    tick(2);
    chk("out_en", {26'h0, chan_out_en}, 32'h1E);
    fl(32'h2100_2100);
    wr(`PBSF_OFS_FLAGS, 32'h2100_0000);
    fl(32'h2100_2100);
    pbsf_brake_model_i.period(6'h21, 0);
    fl(32'h2100_2100);
    pbsf_brake_model_i.drive(6'h3F, 6'h3F);
    tick(3);
    fl(32'h2100_2100);
    chk("out_en", {26'h0, chan_out_en}, 32'h1E);
    pbsf_brake_model_i.period(6'h01, 5);
    tick(1);
    chk("out_en", {26'h0, chan_out_en}, 32'h1F);
    fl(32'h2000_2100);
    pbsf_brake_model_i.period(6'h20, 0);
    fl(32'h0000_2100);
    wr(`PBSF_OFS_FLAGS, 32'h0000_2100);
    fl(32'h0);
    $display("level test done");
    // Set and clear of one flag in the same cycle
    pbsf_brake_model_i.drive(6'h3F, 6'h3B);
    pbsf_brake_model_i.drive(6'h3F, 6'h3F);
    tick(2);
    fork
      wr(`PBSF_OFS_FLAGS, 32'h0000_0004);
      // Fall lands on the edge at which the clear is applied
      begin
        tick(1);
        pbsf_brake_model_i.drive(6'h3F, 6'h3B);
      end
    join
    pbsf_brake_model_i.drive(6'h3F, 6'h3F);
    fl(32'h0004_0004);
    wr(`PBSF_OFS_FLAGS, 32'h0004_0004);
    fl(32'h0);
    $display("collision test done");
    // Reset in mid-run with brakes active
    pbsf_brake_model_i.drive(6'h00, 6'h00);
    tick(3);
    aresetn <= 1'b0;
    pbsf_brake_model_i.drive(6'h3F, 6'h3F);
    tick(6);
    aresetn <= 1'b1;
    reset_table();
    wrap_up();
  end
endmodule
